/* File: design/scss_consts.svh */
`ifndef SCSS_CONSTS_SVH
`define SCSS_CONSTS_SVH

// register byte offsets
`define SCSS_OFS_OSC_CTRL 8'h00
`define SCSS_OFS_T1_CTRL 8'h04
`define SCSS_OFS_CONFIG 8'h08
`define SCSS_OFS_STATUS 8'h0C

// osc_control_reg fields
`define SCSS_OSC_SEL_LSB 0
`define SCSS_OSC_INTERNAL_FREQ_STABLE_FLAG_BIT 2
`define SCSS_OSC_STARTUP_DONE_FLAG_BIT 3
`define SCSS_OSC_IFREQ_LSB 4
// timer_one_control_reg fields
`define SCSS_T1_OSCEN_BIT 3
`define SCSS_T1_RUN_BIT 6
// config fields
`define SCSS_CFG_TWO_SPEED_BIT 3

// clock_select_field codes
`define SCSS_SEL_PRIMARY 2'h0
`define SCSS_SEL_SECONDARY 2'h1

// primary_osc_config codes
`define SCSS_CFG_LP 3'h0
`define SCSS_CFG_XT 3'h1
`define SCSS_CFG_HS 3'h2
`define SCSS_CFG_EC 3'h3
`define SCSS_CFG_INTERNAL_LOWFREQ_OSC_A 3'h4
`define SCSS_CFG_INTERNAL_LOWFREQ_OSC_B 3'h5

// reset values
`define SCSS_SEL_RST 2'h0
`define SCSS_IFREQ_RST 3'h0
`define SCSS_CFG_RST 3'h1
`define SCSS_TWO_SPEED_RST 1'b0

// timing
`define SCSS_OST_COUNT 1024
`define SCSS_HOLD_EDGES 8
`define SCSS_CLK_PERIOD_NS 40
`define SCSS_CPU_DELAY_NS 5000
`define SCSS_CPU_DELAY_CYC ((`SCSS_CPU_DELAY_NS + `SCSS_CLK_PERIOD_NS - 1) / `SCSS_CLK_PERIOD_NS)
`define SCSS_INTERNAL_FREQ_STABLE_FLAG_DELAY_MS 4
`define SCSS_INTERNAL_FREQ_STABLE_FLAG_DELAY_CYC ((`SCSS_INTERNAL_FREQ_STABLE_FLAG_DELAY_MS * 1000000) / `SCSS_CLK_PERIOD_NS)

// axi responses
`define SCSS_RESP_OKAY 2'h0
`define SCSS_RESP_SLVERR 2'h2

`endif

/* File: design/scss_pkg.sv */
package scss_pkg;

  typedef enum logic [1:0] {
    SRC_PRIMARY,
    SRC_SECONDARY,
    SRC_INTERNAL_LOWFREQ_OSC
  } scss_src_e;

  typedef enum logic [2:0] {
    ST_RESET_WAIT,
    ST_RESET_EXTRA,
    ST_RUN,
    ST_OST_WAIT,
    ST_Q1_HOLD,
    ST_SLEEP,
    ST_WAKE_WAIT
  } scss_state_e;

  typedef struct packed {
    logic primary;
    logic secondary;
    logic internal_lowfreq_osc;
  } scss_osc_set_s;

  typedef struct packed {
    logic cpu_run;
    logic q1_hold;
    logic in_sleep;
    scss_src_e sys_src;
  } scss_core_s;

endpackage

/* File: design/scss_fall_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module scss_fall_sync
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // oscillator pin
  input wire logic osc_pin,
  // one-cycle pulse per falling edge
  output logic fall
);
  // pin clocks faster than about aclk/4 alias; fine for slow sources only
  logic [2:0] sync_q;
  logic [2:0] sync_d;
  logic fall_q;
  logic fall_d;

  always_comb
  begin
    sync_d = {sync_q[1:0], osc_pin};
    fall_d = sync_q[2] & ~sync_q[1];
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sync_q <= 3'h0;
      fall_q <= 1'b0;
    end
    else
    begin
      sync_q <= sync_d;
      fall_q <= fall_d;
    end
  end

  assign fall = fall_q;
endmodule
`default_nettype wire

/* File: design/scss_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "scss_consts.svh"
module scss_top
  import scss_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int OST_CYCLES = `SCSS_OST_COUNT,
  parameter int HOLD_EDGES = `SCSS_HOLD_EDGES,
  parameter int CPU_CYCLES = `SCSS_CPU_DELAY_CYC,
  parameter int INTERNAL_FREQ_STABLE_FLAG_CYCLES = `SCSS_INTERNAL_FREQ_STABLE_FLAG_DELAY_CYC
)
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // oscillator pins
  input wire logic prim_osc_pin,
  input wire logic sec_osc_pin,
  input wire logic internal_lowfreq_osc_osc_pin,
  // core side
  input wire logic sleep_req,
  input wire logic wake_irq,
  input wire logic wdt_uses_internal_lowfreq_osc,
  input wire logic fscm_uses_internal_lowfreq_osc,
  // outputs
  output scss_osc_set_s osc_en,
  output scss_core_s core
);
  localparam int OST_W = $clog2(OST_CYCLES + 1);
  localparam int HOLD_W = $clog2(HOLD_EDGES + 1);
  localparam int CPU_W = $clog2(CPU_CYCLES + 1);
  localparam int INTERNAL_FREQ_STABLE_FLAG_W = $clog2(INTERNAL_FREQ_STABLE_FLAG_CYCLES + 1);
  localparam logic [OST_W-1:0] OST_LAST = OST_W'(OST_CYCLES);
  localparam logic [HOLD_W-1:0] HOLD_LAST = HOLD_W'(HOLD_EDGES - 1);
  localparam logic [CPU_W-1:0] CPU_LAST = CPU_W'(CPU_CYCLES);
  localparam logic [INTERNAL_FREQ_STABLE_FLAG_W-1:0] INTERNAL_FREQ_STABLE_FLAG_LAST = INTERNAL_FREQ_STABLE_FLAG_W'(INTERNAL_FREQ_STABLE_FLAG_CYCLES - 1);

  function automatic scss_src_e src_of(input logic [1:0] sel);
    if (sel[1])
      return SRC_INTERNAL_LOWFREQ_OSC;
    else if (sel[0])
      return SRC_SECONDARY;
    else
      return SRC_PRIMARY;
  endfunction

  function automatic logic is_crystal(input logic [2:0] cfg);
    return (cfg == `SCSS_CFG_LP) || (cfg == `SCSS_CFG_XT) || (cfg == `SCSS_CFG_HS);
  endfunction

  // edge pulses
  logic prim_fall_raw;
  logic sec_fall;
  logic internal_lowfreq_osc_fall;
  scss_fall_sync u_prim
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .osc_pin(prim_osc_pin),
    .fall(prim_fall_raw)
  );
  scss_fall_sync u_sec
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .osc_pin(sec_osc_pin),
    .fall(sec_fall)
  );
  scss_fall_sync u_internal_lowfreq_osc
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .osc_pin(internal_lowfreq_osc_osc_pin),
    .fall(internal_lowfreq_osc_fall)
  );

  // register group
  logic [1:0] sel_q, sel_d;
  logic [2:0] ifreq_q, ifreq_d;
  logic sec_en_q, sec_en_d;
  logic [2:0] cfg_q, cfg_d;
  logic two_q, two_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;
  // sequencer group
  scss_state_e state_q, state_d;
  scss_src_e cur_q, cur_d;
  scss_src_e tgt_q, tgt_d;
  logic [OST_W-1:0] ost_q, ost_d;
  logic [HOLD_W-1:0] hold_q, hold_d;
  logic [CPU_W-1:0] cpu_q, cpu_d;
  logic [INTERNAL_FREQ_STABLE_FLAG_W-1:0] internal_freq_stable_flag_cnt_q, internal_freq_stable_flag_cnt_d;
  logic startup_done_flag_q, startup_done_flag_d;
  logic internal_freq_stable_flag_q, internal_freq_stable_flag_d;
  scss_osc_set_s osc_q, osc_d;
  scss_core_s core_q, core_d;

  logic wr_go;
  logic rd_go;
  logic [7:0] wa;
  logic [7:0] ra;
  logic crystal;
  logic prim_fall;
  logic tgt_fall;
  logic ost_done;
  logic cpu_done;
  logic need_ost;
  logic fast_start;
  scss_src_e want;

  // waiting for both channels keeps the write path free of staging flops
  assign wr_go = awvalid && wvalid && !bvalid_q;
  assign rd_go = arvalid && !rvalid_q;
  assign awready = wr_go;
  assign wready = wr_go;
  assign arready = !rvalid_q;
  assign wa = awaddr[7:0];
  assign ra = araddr[7:0];

  always_comb
  begin
    sel_d = sel_q;
    ifreq_d = ifreq_q;
    sec_en_d = sec_en_q;
    cfg_d = cfg_q;
    two_d = two_q;
    bvalid_d = bvalid_q && !bready;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q && !rready;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (wr_go)
    begin
      bvalid_d = 1'b1;
      bresp_d = `SCSS_RESP_OKAY;
      unique case ({wa[7:2], 2'b00})
        `SCSS_OFS_OSC_CTRL:
          if (wstrb[0])
          begin
            sel_d = wdata[`SCSS_OSC_SEL_LSB +: 2];
            ifreq_d = wdata[`SCSS_OSC_IFREQ_LSB +: 3];
          end
        `SCSS_OFS_T1_CTRL:
          if (wstrb[0])
            sec_en_d = wdata[`SCSS_T1_OSCEN_BIT];
        `SCSS_OFS_CONFIG:
          if (wstrb[0])
          begin
            cfg_d = wdata[2:0];
            two_d = wdata[`SCSS_CFG_TWO_SPEED_BIT];
          end
        `SCSS_OFS_STATUS:
          bresp_d = `SCSS_RESP_OKAY;
        default:
          bresp_d = `SCSS_RESP_SLVERR;
      endcase
    end
    // select 01 without the enable does not stick; clearing the enable drops bit 0
    sel_d[0] = sel_d[0] & sec_en_d;
    if (rd_go)
    begin
      rvalid_d = 1'b1;
      rresp_d = `SCSS_RESP_OKAY;
      unique case ({ra[7:2], 2'b00})
        `SCSS_OFS_OSC_CTRL:
          rdata_d = {24'h00_0000, 1'b0, ifreq_q, startup_done_flag_q, internal_freq_stable_flag_q, sel_q};
        `SCSS_OFS_T1_CTRL:
          rdata_d = {24'h00_0000, 1'b0, cur_q == SRC_SECONDARY, 2'h0, sec_en_q, 3'h0};
        `SCSS_OFS_CONFIG:
          rdata_d = {28'h000_0000, two_q, cfg_q};
        `SCSS_OFS_STATUS:
          rdata_d = {24'h00_0000, core_q, osc_q};
        default:
        begin
          rdata_d = 32'h0000_0000;
          rresp_d = `SCSS_RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sel_q <= `SCSS_SEL_RST;
      ifreq_q <= `SCSS_IFREQ_RST;
      sec_en_q <= 1'b0;
      cfg_q <= `SCSS_CFG_RST;
      two_q <= `SCSS_TWO_SPEED_RST;
      bvalid_q <= 1'b0;
      bresp_q <= `SCSS_RESP_OKAY;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `SCSS_RESP_OKAY;
    end
    else
    begin
      sel_q <= sel_d;
      ifreq_q <= ifreq_d;
      sec_en_q <= sec_en_d;
      cfg_q <= cfg_d;
      two_q <= two_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  // internal RC configured as primary counts on its own pin
  assign crystal = is_crystal(cfg_q);
  assign prim_fall = ((cfg_q == `SCSS_CFG_INTERNAL_LOWFREQ_OSC_A) || (cfg_q == `SCSS_CFG_INTERNAL_LOWFREQ_OSC_B)) ? internal_lowfreq_osc_fall : prim_fall_raw;
  assign tgt_fall = (tgt_q == SRC_PRIMARY) ? prim_fall : (tgt_q == SRC_SECONDARY) ? sec_fall : internal_lowfreq_osc_fall;
  assign ost_done = (ost_q == OST_LAST);
  assign cpu_done = (cpu_q == CPU_LAST);
  assign want = src_of(sel_q);
  assign need_ost = (tgt_q == SRC_PRIMARY) && crystal;
  assign fast_start = two_q && need_ost;

  always_comb
  begin
    state_d = state_q;
    cur_d = cur_q;
    tgt_d = tgt_q;
    ost_d = ost_q;
    hold_d = hold_q;
    cpu_d = cpu_q;
    startup_done_flag_d = startup_done_flag_q;
    if (prim_fall && !ost_done)
      ost_d = ost_q + OST_W'(1);
    if (!cpu_done)
      cpu_d = cpu_q + CPU_W'(1);
    unique case (state_q)
      ST_RESET_WAIT:
      begin
        if (fast_start)
          cur_d = SRC_INTERNAL_LOWFREQ_OSC;
        if (cpu_done && (!need_ost || ost_done))
          state_d = ST_RESET_EXTRA;
      end
      ST_RESET_EXTRA:
      begin
        cur_d = SRC_PRIMARY;
        startup_done_flag_d = 1'b1;
        state_d = ST_RUN;
      end
      ST_RUN:
        if (sleep_req)
          state_d = ST_SLEEP;
        else if (want != cur_q)
        begin
          tgt_d = want;
          hold_d = '0;
          ost_d = '0;
          if (want != SRC_PRIMARY)
            startup_done_flag_d = 1'b0;
          if ((want == SRC_PRIMARY) && crystal)
            state_d = ST_OST_WAIT;
          else
            state_d = ST_Q1_HOLD;
        end
      ST_OST_WAIT:
        // core keeps running on the old clock here
        if (sleep_req)
          state_d = ST_SLEEP;
        else if (want != tgt_q)
          state_d = ST_RUN;
        else if (ost_done)
        begin
          hold_d = '0;
          state_d = ST_Q1_HOLD;
        end
      ST_Q1_HOLD:
        if (tgt_fall)
        begin
          hold_d = hold_q + HOLD_W'(1);
          if (hold_q == HOLD_LAST)
          begin
            cur_d = tgt_q;
            startup_done_flag_d = (tgt_q == SRC_PRIMARY);
            state_d = ST_RUN;
          end
        end
      ST_SLEEP:
        if (wake_irq)
        begin
          tgt_d = want;
          cpu_d = '0;
          ost_d = '0;
          startup_done_flag_d = 1'b0;
          state_d = ST_WAKE_WAIT;
        end
      ST_WAKE_WAIT:
      begin
        if (fast_start && cpu_done)
          cur_d = SRC_INTERNAL_LOWFREQ_OSC;
        if (cpu_done && (!need_ost || ost_done))
        begin
          cur_d = tgt_q;
          startup_done_flag_d = (tgt_q == SRC_PRIMARY);
          state_d = ST_RUN;
        end
      end
    endcase
  end

  // stable flag for the scaled internal oscillator; code 0 is the raw RC
  logic internal_freq_stable_flag_run;
  assign internal_freq_stable_flag_run = (cur_q == SRC_INTERNAL_LOWFREQ_OSC) && (state_q == ST_RUN) && (ifreq_q != 3'h0);

  // derived outputs, one cycle behind the state they describe
  logic act_prim;
  logic act_sec;
  logic act_internal_lowfreq_osc;
  logic changing;
  logic awake;
  logic run_now;
  always_comb
  begin
    internal_freq_stable_flag_cnt_d = internal_freq_stable_flag_run && !internal_freq_stable_flag_q ? internal_freq_stable_flag_cnt_q + INTERNAL_FREQ_STABLE_FLAG_W'(1) : '0;
    internal_freq_stable_flag_d = internal_freq_stable_flag_run && (internal_freq_stable_flag_q || (internal_freq_stable_flag_cnt_q == INTERNAL_FREQ_STABLE_FLAG_LAST));
    awake = (state_q != ST_SLEEP);
    changing = (state_q == ST_Q1_HOLD) || (state_q == ST_OST_WAIT) || (state_q == ST_WAKE_WAIT);
    act_prim = ((cur_q == SRC_PRIMARY) && awake) || ((tgt_q == SRC_PRIMARY) && changing)
      || (state_q == ST_RESET_WAIT) || (state_q == ST_RESET_EXTRA);
    act_sec = ((cur_q == SRC_SECONDARY) && awake) || ((tgt_q == SRC_SECONDARY) && changing);
    act_internal_lowfreq_osc = ((cur_q == SRC_INTERNAL_LOWFREQ_OSC) && awake) || ((tgt_q == SRC_INTERNAL_LOWFREQ_OSC) && changing);
    osc_d.primary = act_prim;
    osc_d.secondary = sec_en_q || act_sec;
    osc_d.internal_lowfreq_osc = act_internal_lowfreq_osc || wdt_uses_internal_lowfreq_osc || fscm_uses_internal_lowfreq_osc
      || (act_prim && !crystal && cfg_q[2] && !cfg_q[1]);
    run_now = (state_q == ST_RUN) || (state_q == ST_OST_WAIT)
      || (fast_start && cpu_done && ((state_q == ST_RESET_WAIT) || (state_q == ST_WAKE_WAIT)));
    core_d.cpu_run = run_now;
    core_d.q1_hold = !run_now && awake;
    core_d.in_sleep = (state_q == ST_SLEEP) || ((state_q == ST_WAKE_WAIT) && !run_now);
    core_d.sys_src = cur_q;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_q <= ST_RESET_WAIT;
      cur_q <= SRC_PRIMARY;
      tgt_q <= SRC_PRIMARY;
      ost_q <= '0;
      hold_q <= '0;
      cpu_q <= '0;
      internal_freq_stable_flag_cnt_q <= '0;
      startup_done_flag_q <= 1'b0;
      internal_freq_stable_flag_q <= 1'b0;
      osc_q <= 3'h4;
      core_q <= 5'h08;
    end
    else
    begin
      state_q <= state_d;
      cur_q <= cur_d;
      tgt_q <= tgt_d;
      ost_q <= ost_d;
      hold_q <= hold_d;
      cpu_q <= cpu_d;
      internal_freq_stable_flag_cnt_q <= internal_freq_stable_flag_cnt_d;
      startup_done_flag_q <= startup_done_flag_d;
      internal_freq_stable_flag_q <= internal_freq_stable_flag_d;
      osc_q <= osc_d;
      core_q <= core_d;
    end
  end

  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign osc_en = osc_q;
  assign core = core_q;

  default clocking dcb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  ost_length_a: assert property ((state_q == ST_OST_WAIT) && (state_d == ST_Q1_HOLD) |-> ost_q == OST_LAST)
    else $error("start-up wait ended before its count");
  hold_length_a: assert property ($past(state_q) == ST_Q1_HOLD && state_q == ST_RUN |-> $past(hold_q) == HOLD_LAST)
    else $error("phase-one hold ended early");
  extra_cycle_a: assert property (state_q == ST_RESET_EXTRA |=> state_q == ST_RUN ##1 core_q.cpu_run)
    else $error("extra cycle after reset timers missing");
  reset_hold_a: assert property (state_q == ST_RESET_WAIT && !fast_start |=> !core_q.cpu_run)
    else $error("core ran during reset start-up");
  sel_bit0_a: assert property (!sec_en_q |-> !sel_q[0])
    else $error("select bit 0 set without secondary enable");
  startup_done_flag_src_a: assert property (startup_done_flag_q |-> cur_q == SRC_PRIMARY)
    else $error("start-up flag set off the primary clock");
  internal_freq_stable_flag_delay_a: assert property ($rose(internal_freq_stable_flag_q) |-> $past(internal_freq_stable_flag_cnt_q) == INTERNAL_FREQ_STABLE_FLAG_LAST)
    else $error("stable flag set at wrong time");
  wake_timer_a: assert property ($past(state_q) == ST_WAKE_WAIT && state_q == ST_RUN |-> $past(cpu_q) == CPU_LAST)
    else $error("wake released before core start-up timer");
  run_on_old_a: assert property (state_q == ST_OST_WAIT && !sleep_req && want == tgt_q |=> core_q.cpu_run)
    else $error("core stalled during crystal start-up");
  bresp_hold_a: assert property (bvalid_q && !bready |=> bvalid_q && $stable(bresp_q))
    else $error("write response dropped");
endmodule
`default_nettype wire

/* File: sim/scss_osc_model.sv */
`timescale 1ns/1ps
`default_nettype none
module scss_osc_model
  import scss_pkg::*;
(
  // enables from the block
  input wire scss_osc_set_s osc_en,
  // oscillator pins
  output logic prim_pin,
  output logic sec_pin,
  output logic internal_lowfreq_osc_pin
);
  // a stopped oscillator rests low; periods stay above four aclk periods so the synchroniser sees every edge
  initial
  begin
    prim_pin = 1'b0;
    sec_pin = 1'b0;
    internal_lowfreq_osc_pin = 1'b0;
  end
  always #100 prim_pin = osc_en.primary ? ~prim_pin : 1'b0;
  always #260 sec_pin = osc_en.secondary ? ~sec_pin : 1'b0;
  always #180 internal_lowfreq_osc_pin = osc_en.internal_lowfreq_osc ? ~internal_lowfreq_osc_pin : 1'b0;
endmodule
`default_nettype wire

/* File: sim/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "scss_consts.svh"
module testbench
  import scss_pkg::*;
;
  // shortened counts keep the run brief
  localparam int OSC_STARTUP_TIMER = 16;
  localparam int CPU = 8;
  localparam int INTERNAL_FREQ_STABLE_FLAG = 50;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic sleep_req = 1'b0;
  logic wake_irq = 1'b0;
  logic wdt_uses_internal_lowfreq_osc = 1'b0;
  logic fscm_uses_internal_lowfreq_osc = 1'b0;
  logic awready;
  logic wready;
  logic bvalid;
  logic arready;
  logic rvalid;
  logic [1:0] bresp;
  logic [1:0] rresp;
  logic [31:0] rdata;
  logic prim_pin;
  logic sec_pin;
  logic internal_lowfreq_osc_pin;
  scss_osc_set_s osc_en;
  scss_core_s core;
  int miscompares = 0;
  int samples_checked = 0;
  logic [31:0] rd;
  logic [1:0] rsp;

  scss_top #(.OST_CYCLES(OSC_STARTUP_TIMER), .CPU_CYCLES(CPU), .INTERNAL_FREQ_STABLE_FLAG_CYCLES(INTERNAL_FREQ_STABLE_FLAG)) uut (.aclk(aclk), .aresetn(aresetn),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
    .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .prim_osc_pin(prim_pin),
    .sec_osc_pin(sec_pin), .internal_lowfreq_osc_osc_pin(internal_lowfreq_osc_pin), .sleep_req(sleep_req), .wake_irq(wake_irq),
    .wdt_uses_internal_lowfreq_osc(wdt_uses_internal_lowfreq_osc), .fscm_uses_internal_lowfreq_osc(fscm_uses_internal_lowfreq_osc), .osc_en(osc_en), .core(core));

  scss_osc_model oscs (.osc_en(osc_en), .prim_pin(prim_pin), .sec_pin(sec_pin), .internal_lowfreq_osc_pin(internal_lowfreq_osc_pin));

  always #20 aclk = ~aclk;

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // readies are combinational, so they are looked at on the falling edge, away from the updates
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    bready <= 1'b1;
    do @(negedge aclk); while (awready !== 1'b1 || wready !== 1'b1);
    @(posedge aclk);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(negedge aclk); while (bvalid !== 1'b1);
    rsp = bresp;
    @(posedge aclk);
    bready <= 1'b0;
  endtask

  task automatic axr(input logic [7:0] a);
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do @(negedge aclk); while (arready !== 1'b1);
    @(posedge aclk);
    arvalid <= 1'b0;
    do @(negedge aclk); while (rvalid !== 1'b1);
    rd = rdata;
    rsp = rresp;
    @(posedge aclk);
    rready <= 1'b0;
  endtask

  // core bits: cpu_run 4, q1_hold 3, in_sleep 2, sys_src 1:0
  task automatic wait_core(input logic [4:0] m, input logic [4:0] v, input int lim, input string what);
    int n;
    n = 0;
    while ((core & m) !== v && n < lim)
    begin
      @(negedge aclk);
      n++;
    end
    chk(what, {27'h0, v}, {27'h0, core & m});
  endtask

  task automatic sleep_wake();
    @(posedge aclk);
    sleep_req <= 1'b1;
    @(posedge aclk);
    sleep_req <= 1'b0;
    repeat (3) @(negedge aclk);
    chk("asleep", 32'h04, {27'h0, core & 5'h14});
    @(posedge aclk);
    wake_irq <= 1'b1;
    @(posedge aclk);
    wake_irq <= 1'b0;
  endtask

  task automatic t_reset();
    repeat (20) @(negedge aclk);
    chk("core held", 32'h08, {27'h0, core});
    wait_core(5'h13, 5'h10, 400, "run on primary");
    @(negedge aclk);
    chk("osc enables", 32'h4, {29'h0, osc_en});
    axr(`SCSS_OFS_OSC_CTRL);
    chk("osc ctrl", 32'h08, rd);
    axr(`SCSS_OFS_CONFIG);
    chk("config", 32'h01, rd);
    axr(8'h10);
    chk("unmapped resp", 32'h2, {30'h0, rsp});
    chk("unmapped data", 32'h0, rd);
    $display("test reset done");
  endtask

  task automatic t_secondary();
    axw(`SCSS_OFS_T1_CTRL, 32'h08);
    axw(`SCSS_OFS_OSC_CTRL, 32'h01);
    wait_core(5'h13, 5'h11, 400, "run on secondary");
    axr(`SCSS_OFS_T1_CTRL);
    chk("t1 ctrl", 32'h48, rd);
    axr(`SCSS_OFS_OSC_CTRL);
    chk("osc ctrl", 32'h01, rd);
    axw(`SCSS_OFS_T1_CTRL, 32'h00);
    axr(`SCSS_OFS_OSC_CTRL);
    chk("select cleared", 32'h00, rd);
    @(negedge aclk);
    chk("core during start-up", 32'h11, {27'h0, core});
    wait_core(5'h13, 5'h10, 400, "back on primary");
    repeat (2) @(negedge aclk);
    chk("secondary off", 32'h0, {31'h0, osc_en.secondary});
    $display("test secondary done");
  endtask

  task automatic t_internal();
    axw(`SCSS_OFS_OSC_CTRL, 32'h12);
    wait_core(5'h13, 5'h12, 400, "run on internal");
    axr(`SCSS_OFS_OSC_CTRL);
    chk("flags clear", 32'h12, rd);
    axr(`SCSS_OFS_T1_CTRL);
    chk("secondary flag", 32'h00, rd);
    repeat (INTERNAL_FREQ_STABLE_FLAG + 4) @(negedge aclk);
    axr(`SCSS_OFS_OSC_CTRL);
    chk("stable flag", 32'h16, rd);
    axw(`SCSS_OFS_CONFIG, 32'h03);
    axw(`SCSS_OFS_OSC_CTRL, 32'h10);
    // a crystal return would need the start-up count on top of the eight edges
    wait_core(5'h13, 5'h10, 70, "primary without start-up");
    repeat (2) @(negedge aclk);
    chk("internal off", 32'h0, {31'h0, osc_en.internal_lowfreq_osc});
    @(posedge aclk);
    fscm_uses_internal_lowfreq_osc <= 1'b1;
    repeat (3) @(negedge aclk);
    chk("internal kept", 32'h1, {31'h0, osc_en.internal_lowfreq_osc});
    @(posedge aclk);
    fscm_uses_internal_lowfreq_osc <= 1'b0;
    axr(`SCSS_OFS_OSC_CTRL);
    chk("on primary", 32'h18, rd);
    $display("test internal done");
  endtask

  task automatic t_sleep();
    axw(`SCSS_OFS_CONFIG, 32'h01);
    sleep_wake();
    repeat (20) @(negedge aclk);
    chk("still asleep", 32'h04, {27'h0, core & 5'h14});
    wait_core(5'h13, 5'h10, 400, "woke on primary");
    axr(`SCSS_OFS_OSC_CTRL);
    chk("select kept", 32'h18, rd);
    axw(`SCSS_OFS_OSC_CTRL, 32'h12);
    wait_core(5'h13, 5'h12, 400, "run on internal");
    sleep_wake();
    wait_core(5'h13, 5'h12, CPU + 32, "woke on internal");
    // sleep taken while the crystal is still starting
    axw(`SCSS_OFS_OSC_CTRL, 32'h10);
    repeat (2) @(negedge aclk);
    chk("running during start-up", 32'h12, {27'h0, core});
    sleep_wake();
    wait_core(5'h13, 5'h10, 400, "resumed on primary");
    // two-speed wake runs on internal RC while the crystal count goes on
    axw(`SCSS_OFS_CONFIG, 32'h09);
    sleep_wake();
    wait_core(5'h13, 5'h12, CPU + 32, "two-speed on internal");
    wait_core(5'h13, 5'h10, 400, "primary after two-speed");
    $display("test sleep done");
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_secondary();
    t_internal();
    t_sleep();
    give_verdict();
  end

  // the whole sequence needs about a thousand cycles
  initial
  begin
    repeat (20000) @(posedge aclk);
    miscompares++;
    give_verdict();
  end
endmodule
`default_nettype wire
